/* File: strap_pkg.sv */
// Constants and types shared by both ends of the strap, clock-pin and LED link.
// Assumes both ends run on one 40 MHz system clock and see the pins through rmii_strap_if.
package strap_pkg;
  localparam int SYS_PERIOD_NS = 25;
  localparam int REFCLK_PERIOD_NS = 200;
  localparam int REF_HALF_CYC = REFCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int XTAL_PERIOD_NS = 400;
  localparam int XTAL_HALF_CYC = XTAL_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int HW_RESET_HOLD_NS = 100000;
  localparam int HW_RESET_HOLD_CYC = (HW_RESET_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int BLINK_HALF_NS = 50000000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / SYS_PERIOD_NS;
  localparam logic REGULATOR_OFF_STRAP_RESET = 1'b0;
  localparam logic INTSEL_RESET = 1'b1;
  typedef enum logic [1:0] {ST_POR_SETTLE, ST_RUN, ST_HW_HOLD, ST_HW_SETTLE} dev_state_t;
endpackage

/* File: rmii_strap_if.sv */
// Pins between the transceiver end and the MAC end.
// Works out shared pin levels from the enables and the strap pulls.
`timescale 1ns/100ps
interface rmii_strap_if;
  logic hw_reset_n;
  logic clock_input_pin;
  logic regulator_off_strap_pull;
  logic intsel_pull;
  logic link_activity_led_o;
  logic link_activity_led_oe;
  logic speed_led_o;
  logic speed_led_oe;
  logic intclk_o;
  logic intclk_oe;
  logic link_activity_led;
  logic speed_led;
  logic intclk_pin;
  logic txen;
  logic [1:0] txd;
  logic crs_dv;
  logic [1:0] rxd;
  logic rxer;
  assign link_activity_led = link_activity_led_oe ? link_activity_led_o : regulator_off_strap_pull;
  assign speed_led = speed_led_oe ? speed_led_o : intsel_pull;
  assign intclk_pin = intclk_oe ? intclk_o : 1'b1;
  modport device (
    input hw_reset_n, clock_input_pin, link_activity_led, speed_led, txen, txd,
    output link_activity_led_o, link_activity_led_oe, speed_led_o, speed_led_oe, intclk_o, intclk_oe, crs_dv, rxd, rxer
  );
  modport host (
    input intclk_pin, crs_dv, rxd, rxer,
    output hw_reset_n, clock_input_pin, regulator_off_strap_pull, intsel_pull, txen, txd
  );
endinterface

/* File: phy_strap_end.sv */
// Transceiver end: strap latching, clock-pin function, LEDs, carrier and RMII data paths.
// Assumes the MAC end keeps hw_reset_n low for the hold time and drives the clock pin.
`timescale 1ns/100ps
module phy_strap_end
  import strap_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC,
  parameter int RX_DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  rmii_strap_if.device pins,
  input wire logic i_link_up,
  input wire logic i_speed_100,
  input wire logic i_isolate,
  input wire logic i_full_duplex,
  input wire logic i_repeater,
  input wire logic i_rx_active,
  input wire logic i_irq,
  input wire logic i_rx_valid,
  input wire logic [1:0] i_rx_data,
  output logic o_regulator_en,
  output logic o_refclk_out_mode,
  output logic o_straps_valid,
  output logic o_crs,
  output logic o_tx_valid,
  output logic [1:0] o_tx_data
);
  localparam int PW = $clog2(RX_DEPTH);
  localparam int BW = $clog2(BLINK_CYC + 1);

  typedef struct packed {
    dev_state_t st;
    logic [1:0] led_s1;
    logic [1:0] led_s2;
    logic [1:0] ck_s;
    logic ck_prev;
    logic [1:0] rst_s;
    logic rst_prev;
    logic [2:0] tx_s1;
    logic [2:0] tx_s2;
    logic regulator_off_strap;
    logic intsel;
    logic [15:0] settle;
    logic [BW-1:0] blink_cnt;
    logic blink;
    logic [3:0] div;
    logic refclk_gen;
    logic gen_prev;
    logic tx_en;
    logic [1:0] tx_d;
    logic [RX_DEPTH-1:0][1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] fill;
    logic overflow;
    logic crs_dv;
    logic [1:0] rxd;
    logic rxer;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic ref_edge;
  logic crs;
  logic released;

  assign ref_edge = s_reg.intsel ? (s_reg.ck_s[1] & ~s_reg.ck_prev)
                                 : (s_reg.refclk_gen & ~s_reg.gen_prev);
  assign crs = (i_repeater | i_full_duplex) ? i_rx_active : (i_rx_active | s_reg.tx_s2[2]);
  assign released = (s_reg.st != ST_RUN);

  always_comb begin
    s_next = s_reg;
    s_next.led_s1 = {pins.speed_led, pins.link_activity_led};
    s_next.led_s2 = s_reg.led_s1;
    s_next.ck_s = {s_reg.ck_s[0], pins.clock_input_pin};
    s_next.ck_prev = s_reg.ck_s[1];
    s_next.rst_s = {s_reg.rst_s[0], pins.hw_reset_n};
    s_next.rst_prev = s_reg.rst_s[1];
    s_next.tx_s1 = {pins.txen, pins.txd};
    s_next.tx_s2 = s_reg.tx_s1;
    s_next.gen_prev = s_reg.refclk_gen;
    case (s_reg.st)
      ST_POR_SETTLE: begin
        if (s_reg.settle == 16'(STRAP_SETTLE_CYC - 1)) begin
          s_next.regulator_off_strap = s_reg.led_s2[0];
          s_next.intsel = s_reg.led_s2[1];
          s_next.st = ST_RUN;
        end else begin
          s_next.settle = s_reg.settle + 16'h0001;
        end
      end
      ST_RUN: begin
        if (!s_reg.rst_s[1]) begin
          s_next.st = ST_HW_HOLD;
        end
      end
      ST_HW_HOLD: begin
        s_next.settle = 16'h0000;
        if (s_reg.rst_s[1] && !s_reg.rst_prev) begin
          s_next.st = ST_HW_SETTLE;
        end
      end
      default: begin
        if (!s_reg.rst_s[1]) begin
          s_next.st = ST_HW_HOLD;
        end else if (s_reg.settle == 16'(STRAP_SETTLE_CYC - 1)) begin
          s_next.intsel = s_reg.led_s2[1];
          s_next.st = ST_RUN;
        end else begin
          s_next.settle = s_reg.settle + 16'h0001;
        end
      end
    endcase
    // Reference clock made from own clock in output mode
    if (s_reg.div == 4'(REF_HALF_CYC - 1)) begin
      s_next.div = 4'h0;
      s_next.refclk_gen = ~s_reg.refclk_gen;
    end else begin
      s_next.div = s_reg.div + 4'h1;
    end
    if (s_reg.blink_cnt == BW'(BLINK_CYC - 1)) begin
      s_next.blink_cnt = '0;
      s_next.blink = ~s_reg.blink;
    end else begin
      s_next.blink_cnt = s_reg.blink_cnt + 1'b1;
    end
    // Transmit pins taken on the reference edge after two synchronizer stages
    if (ref_edge) begin
      s_next.tx_en = s_reg.tx_s2[2];
      s_next.tx_d = s_reg.tx_s2[1:0];
    end
    // Elasticity buffer: recovered-data strobe in, reference edge out
    if (i_rx_valid && s_reg.fill != (PW+1)'(RX_DEPTH)) begin
      s_next.mem[s_reg.wr_ptr] = i_rx_data;
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end else if (i_rx_valid) begin
      s_next.overflow = 1'b1;
    end
    if (ref_edge) begin
      if (s_reg.fill != '0) begin
        s_next.crs_dv = 1'b1;
        s_next.rxd = s_reg.mem[s_reg.rd_ptr];
        s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
      end else begin
        s_next.crs_dv = crs;
        s_next.rxd = 2'h0;
      end
      s_next.rxer = s_reg.overflow;
      s_next.overflow = i_rx_valid && s_reg.fill == (PW+1)'(RX_DEPTH);
    end
    s_next.fill = s_reg.fill
                  + (PW+1)'(i_rx_valid && s_reg.fill != (PW+1)'(RX_DEPTH))
                  - (PW+1)'(ref_edge && s_reg.fill != '0);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_reg <= '0;
      s_reg.st <= ST_POR_SETTLE;
      s_reg.regulator_off_strap <= REGULATOR_OFF_STRAP_RESET;
      s_reg.intsel <= INTSEL_RESET;
      s_reg.rst_s <= 2'h3;
      s_reg.rst_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // LED pins released while straps are read, then driven with strap polarity
  assign pins.link_activity_led_oe = ~released;
  assign pins.link_activity_led_o = (i_link_up & (~crs | s_reg.blink)) ^ s_reg.regulator_off_strap;
  assign pins.speed_led_oe = ~released;
  assign pins.speed_led_o = (i_speed_100 & ~i_isolate) ^ s_reg.intsel;
  assign pins.intclk_oe = ~released;
  assign pins.intclk_o = s_reg.intsel ? ~i_irq : s_reg.refclk_gen;
  assign pins.crs_dv = s_reg.crs_dv;
  assign pins.rxd = s_reg.rxd;
  assign pins.rxer = s_reg.rxer;
  assign o_regulator_en = ~s_reg.regulator_off_strap;
  assign o_refclk_out_mode = ~s_reg.intsel;
  assign o_straps_valid = ~released;
  assign o_crs = crs;
  assign o_tx_valid = s_reg.tx_en;
  assign o_tx_data = s_reg.tx_d;
endmodule

/* File: mac_strap_end.sv */
// MAC end: strap pulls, hardware reset, reference clock source and RMII data.
// Assumes the transceiver end latches straps while it releases its LED pins.
`timescale 1ns/100ps
module mac_strap_end
  import strap_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  rmii_strap_if.host pins,
  input wire logic i_regulator_off_strap_sel,
  input wire logic i_intsel_sel,
  input wire logic i_phy_reset_req,
  input wire logic i_tx_valid,
  input wire logic [1:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [1:0] o_rx_data,
  output logic o_rx_error,
  output logic o_phy_irq,
  output logic o_reset_busy
);
  typedef struct packed {
    logic regulator_off_strap_pull;
    logic intsel_pull;
    logic [12:0] hold;
    logic rst_n;
    logic [3:0] div;
    logic clk_out;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic pin_prev;
    logic [3:0] rx_s1;
    logic [3:0] rx_s2;
    logic txen;
    logic [1:0] txd;
    logic rx_valid;
    logic [1:0] rx_data;
    logic rx_err;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic in_mode;
  logic ref_edge;

  assign in_mode = s_reg.intsel_pull;
  assign ref_edge = in_mode ? (s_reg.div == 4'(REF_HALF_CYC - 1) && !s_reg.clk_out)
                            : (s_reg.pin_s2[0] & ~s_reg.pin_prev);

  always_comb begin
    s_next = s_reg;
    s_next.regulator_off_strap_pull = i_regulator_off_strap_sel;
    s_next.intsel_pull = i_intsel_sel;
    s_next.pin_s1 = {1'b0, pins.intclk_pin};
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_prev = s_reg.pin_s2[0];
    s_next.rx_s1 = {pins.crs_dv, pins.rxer, pins.rxd};
    s_next.rx_s2 = s_reg.rx_s1;
    if (i_phy_reset_req) begin
      s_next.hold = '0;
      s_next.rst_n = 1'b0;
    end else if (s_reg.hold == 13'(HW_RESET_HOLD_CYC - 1)) begin
      s_next.rst_n = 1'b1;
    end else begin
      s_next.hold = s_reg.hold + 13'h0001;
    end
    // 5 MHz reference stand-in in input mode, 2.5 MHz crystal stand-in in output mode
    if (s_reg.div == 4'(in_mode ? REF_HALF_CYC - 1 : XTAL_HALF_CYC - 1)) begin
      s_next.div = 4'h0;
      s_next.clk_out = ~s_reg.clk_out;
    end else begin
      s_next.div = s_reg.div + 4'h1;
    end
    if (ref_edge) begin
      s_next.txen = i_tx_valid;
      s_next.txd = i_tx_data;
      s_next.rx_valid = s_reg.rx_s2[3];
      s_next.rx_err = s_reg.rx_s2[2];
      s_next.rx_data = s_reg.rx_s2[1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      s_reg <= '0;
      s_reg.intsel_pull <= INTSEL_RESET;
      s_reg.regulator_off_strap_pull <= REGULATOR_OFF_STRAP_RESET;
      s_reg.pin_s1 <= 2'h1;
      s_reg.pin_s2 <= 2'h1;
      s_reg.pin_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins.regulator_off_strap_pull = s_reg.regulator_off_strap_pull;
  assign pins.intsel_pull = s_reg.intsel_pull;
  assign pins.hw_reset_n = s_reg.rst_n;
  assign pins.clock_input_pin = s_reg.clk_out;
  assign pins.txen = s_reg.txen;
  assign pins.txd = s_reg.txd;
  assign o_tx_ready = ref_edge & s_reg.rst_n;
  assign o_rx_valid = s_reg.rx_valid;
  assign o_rx_data = s_reg.rx_data;
  assign o_rx_error = s_reg.rx_err;
  assign o_phy_irq = in_mode & ~s_reg.pin_s2[0];
  assign o_reset_busy = ~s_reg.rst_n;
endmodule

/* File: strap_chk.sv */
// Checker on the shared strap, clock and RMII pins.
// Assumes tb_top places it beside the interface.
`timescale 1ns/100ps
module strap_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic hw_reset_n,
  input wire logic intsel_pull,
  input wire logic link_activity_led_oe,
  input wire logic speed_led_oe,
  input wire logic intclk_pin,
  input wire logic txen,
  input wire logic [1:0] txd,
  input wire logic [1:0] rxd,
  input wire logic rxer
);
  logic sel_reg;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Pin strap as last seen while released
  always_ff @(posedge i_sys_clk) begin
    if (!speed_led_oe) begin
      sel_reg <= intsel_pull;
    end
  end
  a_pins_released: assert property ($fell(hw_reset_n) |-> ##[1:4] !speed_led_oe) else $error("pins held");
  a_settle_wait: assert property ($rose(hw_reset_n) |-> !speed_led_oe [*8]) else $error("early latch");
  a_oe_paired: assert property (link_activity_led_oe == speed_led_oe) else $error("oe split");
  a_reset_hold: assert property ($fell(hw_reset_n) |=> !hw_reset_n [*8]) else $error("short reset");
  a_refclk_half: assert property (disable iff (i_rst || !hw_reset_n)
    speed_led_oe && $past(speed_led_oe) && !sel_reg && $changed(intclk_pin) |=>
    $stable(intclk_pin) [*3] ##1 $changed(intclk_pin)) else $error("refclk period");
  a_tx_paced: assert property (speed_led_oe && $past(speed_led_oe, 8) && $changed({txen, txd}) |=>
    $stable({txen, txd}) [*7]) else $error("tx pace");
  a_rx_paced: assert property (speed_led_oe && $past(speed_led_oe, 8) && $changed(rxd) |=>
    $stable(rxd) [*7]) else $error("rx pace");
  a_rxer_period: assert property ($rose(rxer) |=> rxer [*7]) else $error("rxer short");
  c_overflow: cover property ($rose(rxer));
  c_out_mode: cover property ($rose(speed_led_oe) && !intsel_pull);
  c_in_mode: cover property ($rose(speed_led_oe) && intsel_pull);
endmodule

/* File: tb_top.sv */
// Bench joining both ends, random levels and dibits.
// Assumes the package timing and a blink half period of 8 cycles.
`timescale 1ns/100ps
module tb_top;
  import strap_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic link = 1'b0, spd = 1'b0, iso = 1'b0, fdx = 1'b1, rep = 1'b0, rxa = 1'b0, irq = 1'b0;
  logic rxv = 1'b0, roff = 1'b0, isel = 1'b1, preq = 1'b0, txv = 1'b0;
  logic [1:0] rxdat = 2'h0, txdat = 2'h0, d, f, ptx_d, mrx_d;
  logic reg_en, out_mode, valid, crs, ptx_v, rdy, mrx_v, mrx_err, mirq, busy, pl, pc;
  logic [7:0] rv;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n, t;
  rmii_strap_if pins ();
  always #12.5 i_sys_clk = ~i_sys_clk;
  phy_strap_end #(.BLINK_CYC(8)) phy_strap_end_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .pins(pins.device),
    .i_link_up(link), .i_speed_100(spd), .i_isolate(iso), .i_full_duplex(fdx), .i_repeater(rep),
    .i_rx_active(rxa), .i_irq(irq), .i_rx_valid(rxv), .i_rx_data(rxdat), .o_regulator_en(reg_en),
    .o_refclk_out_mode(out_mode), .o_straps_valid(valid), .o_crs(crs), .o_tx_valid(ptx_v), .o_tx_data(ptx_d));
  mac_strap_end mac_strap_end_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .pins(pins.host),
    .i_regulator_off_strap_sel(roff), .i_intsel_sel(isel), .i_phy_reset_req(preq), .i_tx_valid(txv), .i_tx_data(txdat),
    .o_tx_ready(rdy), .o_rx_valid(mrx_v), .o_rx_data(mrx_d), .o_rx_error(mrx_err), .o_phy_irq(mirq),
    .o_reset_busy(busy));
  strap_chk strap_chk_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .hw_reset_n(pins.hw_reset_n),
    .intsel_pull(pins.intsel_pull), .link_activity_led_oe(pins.link_activity_led_oe), .speed_led_oe(pins.speed_led_oe), .intclk_pin(pins.intclk_pin),
    .txen(pins.txen), .txd(pins.txd), .rxd(pins.rxd), .rxer(pins.rxer));
  task automatic cmp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %b want %b", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_run();
    int w;
    w = 0;
    do begin
      @(negedge i_sys_clk);
      w++;
    end while (!(valid === 1'b1 && busy === 1'b0) && w < 5000);
    cmp({valid, busy}, 2'b10);
  endtask
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    void'($urandom(67064));
    for (int k = 0; k < 4; k++) begin
      @(posedge i_sys_clk);
      i_rst <= 1'b1;
      {roff, isel} <= 2'(k);
      repeat (5) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      wait_run();
      cmp({reg_en, out_mode}, ~{roff, isel});
      repeat (12) begin
        rv = 8'($urandom);
        @(posedge i_sys_clk);
        {link, spd, iso, irq, rep, fdx} <= rv[5:0];
        repeat (4) @(negedge i_sys_clk);
        cmp({pins.link_activity_led, pins.speed_led}, {link ^ roff, (spd & ~iso) ^ isel});
        cmp({mirq, crs}, {irq & isel, 1'b0});
        if (isel) cmp({pins.intclk_pin, 1'b0}, {~irq, 1'b0});
      end
      @(posedge i_sys_clk);
      {link, rxa} <= 2'b11;
      @(negedge i_sys_clk);
      t = 0;
      n = 0;
      repeat (80) begin
        pl = pins.link_activity_led;
        pc = pins.intclk_pin;
        @(negedge i_sys_clk);
        t += int'(pl !== pins.link_activity_led);
        n += int'(pc !== pins.intclk_pin);
      end
      cmp({crs, t > 2}, 2'b11);
      if (!isel) cmp({1'b0, n == 20}, 2'b01);
      @(posedge i_sys_clk);
      {rxa, txv, txdat} <= {2'b01, 2'(k)};
      repeat (6) begin
        n = 0;
        do begin
          @(negedge i_sys_clk);
          n++;
        end while (rdy !== 1'b1 && n < 40);
        d = txdat;
        @(posedge i_sys_clk);
        txdat <= d ^ 2'($urandom_range(3, 1));
        n = 0;
        do begin
          @(negedge i_sys_clk);
          n++;
        end while (!(ptx_v === 1'b1 && ptx_d === d) && n < 30);
        cmp(ptx_d, d);
        cmp({ptx_v, crs}, {1'b1, ~(fdx | rep)});
      end
      @(posedge i_sys_clk);
      {txv, fdx} <= 2'b01;
      f = 2'($urandom_range(3, 1));
      repeat (20) @(posedge i_sys_clk);
      for (int i = 0; i < 12; i++) begin
        rxv <= 1'b1;
        rxdat <= (i == 0) ? f : 2'($urandom);
        @(posedge i_sys_clk);
      end
      rxv <= 1'b0;
      n = 0;
      do begin
        @(negedge i_sys_clk);
        n++;
      end while (mrx_v !== 1'b1 && n < 60);
      cmp(mrx_d, f);
      do begin
        @(negedge i_sys_clk);
        n++;
      end while (mrx_err !== 1'b1 && n < 150);
      cmp({mrx_err, 1'b0}, 2'b10);
      repeat (150) @(posedge i_sys_clk);
      isel <= ~isel;
      repeat (30) @(negedge i_sys_clk);
      cmp({reg_en, out_mode}, {~roff, isel});
      @(posedge i_sys_clk);
      preq <= 1'b1;
      @(posedge i_sys_clk);
      preq <= 1'b0;
      repeat (10) @(negedge i_sys_clk);
      wait_run();
      cmp({reg_en, out_mode}, ~{roff, isel});
    end
    close_out();
  end
endmodule
